// >>> logic/scfg_pkg.sv
package scfg_pkg;

	// direct management register numbers
	localparam logic [4:0] REG_IND_CTRL = 5'h0d;
	localparam logic [4:0] REG_IND_DATA = 5'h0e;
	localparam logic [4:0] REG_LINK_CTRL = 5'h18;
	localparam logic [4:0] REG_LINK_STAT = 5'h19;
	localparam logic [4:0] REG_STRAP_STAT = 5'h1a;

	// extended space
	localparam logic [11:0] EXT_DIRECT_TOP = 12'h01f;
	localparam logic [11:0] EXT_LED_CFG = 12'h460;
	localparam logic [4:0] FIELD_VENDOR = 5'h1f;
	localparam logic [4:0] FIELD_PMA = 5'h01;
	localparam int IND_FN_LSB = 14;
	localparam int IND_FIELD_W = 5;
	localparam int EXT_ADDR_W = 12;

	// indirect control function codes
	typedef enum logic [1:0] {
		IND_FN_ADDR = 2'h0,
		IND_FN_DATA = 2'h1,
		IND_FN_DATA_INC_RW = 2'h2,
		IND_FN_DATA_INC_WR = 2'h3
	} scfg_ind_fn_t;

	// field positions of the local registers
	localparam int LED0_SEL_LSB = 0;
	localparam int LED1_SEL_LSB = 4;
	localparam int LED2_SEL_LSB = 8;
	localparam int LED_SEL_W = 4;
	localparam int REFERENCE_CLOCK_OUTPUT_SEL_BIT = 12;
	localparam int LINK_PERMIT_BIT = 0;
	localparam int LINK_RESTART_BIT = 15;
	localparam int STAT_FAULT_BIT = 0;
	localparam int STAT_LINK_BIT = 1;
	localparam int STAT_ERRCNT_LSB = 8;
	localparam int ERRCNT_W = 8;

	// reset values and the error count limit
	localparam logic [15:0] LED_CFG_RESET = 16'h0000;
	localparam logic LINK_PERMIT_RESET = 1'b0;
	localparam logic [ERRCNT_W-1:0] ERRCNT_MAX = 8'hff;

	typedef enum logic [2:0] {
		HOST_IF_SGMII = 3'h0,
		HOST_IF_MII = 3'h1,
		HOST_IF_RMII_SLAVE = 3'h2,
		HOST_IF_RMII_MASTER = 3'h3,
		HOST_IF_RGMII_ALIGN = 3'h4,
		HOST_IF_RGMII_TXD = 3'h5,
		HOST_IF_RGMII_TXRXD = 3'h6,
		HOST_IF_RGMII_RXD = 3'h7
	} scfg_host_if_t;

	typedef enum logic [2:0] {
		TEST_NORMAL = 3'h0,
		TEST_MODE_1 = 3'h1,
		TEST_MODE_2 = 3'h2,
		TEST_MODE_4 = 3'h4,
		TEST_MODE_5 = 3'h5,
		TEST_RESERVED = 3'h7
	} scfg_test_t;

	// four-level strap: comparator code 0..3 stands for levels 1..4
	typedef struct packed {
		logic [1:0] rx_valid;
		logic [1:0] rx_error;
		logic [2:0][1:0] rx_data;
	} scfg_strap_pins_t;

	typedef struct packed {
		scfg_host_if_t host_interface_select;
		scfg_test_t test_mode;
		logic [4:0] port_address_strap;
		logic master_slave_strap;
		logic managed_start;
		logic [2:0] indicator_level;
	} scfg_strap_cfg_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] port;
		logic [4:0] regnum;
		logic [15:0] wdata;
	} scfg_mgmt_req_t;

	// level 1..4 -> {first, second} = 00, 01, 11, 10
	function automatic logic [1:0] level_bits(input logic [1:0] code);
		level_bits = {code[1], code[1] ^ code[0]};
	endfunction

endpackage

// >>> logic/scfg_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none
module scfg_strap_latch (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// strap levels
	input wire scfg_pkg::scfg_strap_pins_t pins,
	input wire logic [2:0] indicator_in,
	// decoded result
	output scfg_pkg::scfg_strap_cfg_t cfg,
	output logic strap_valid
);
	import scfg_pkg::*;

	typedef enum logic [1:0] {
		ST_SAMPLE = 2'b00,
		ST_HOLD = 2'b01
	} scfg_strap_st_t;

	scfg_strap_st_t state_reg;
	scfg_strap_cfg_t cfg_reg;
	scfg_strap_cfg_t cfg_next;
	logic [1:0] dv_b, er_b, d0_b, d1_b, d2_b;
	logic [2:0] test_raw;

	always_comb begin
		dv_b = level_bits(pins.rx_valid);
		er_b = level_bits(pins.rx_error);
		d0_b = level_bits(pins.rx_data[0]);
		d1_b = level_bits(pins.rx_data[1]);
		d2_b = level_bits(pins.rx_data[2]);
		cfg_next = cfg_reg;
		cfg_next.host_interface_select = scfg_host_if_t'({d2_b[1], d1_b[1], d0_b[1]});
		test_raw = {d2_b[0], d1_b[0], d0_b[0]};
		case (test_raw)
			3'h0: cfg_next.test_mode = TEST_NORMAL;
			3'h1: cfg_next.test_mode = TEST_MODE_1;
			3'h2: cfg_next.test_mode = TEST_MODE_2;
			3'h4: cfg_next.test_mode = TEST_MODE_4;
			3'h5: cfg_next.test_mode = TEST_MODE_5;
			default: cfg_next.test_mode = TEST_RESERVED;
		endcase
		// all-low straps give address zero; top bit always zero
		cfg_next.port_address_strap = {1'b0, er_b[0], dv_b[0], er_b[1], dv_b[1]};
		cfg_next.master_slave_strap = indicator_in[0];
		cfg_next.managed_start = indicator_in[1];
		cfg_next.indicator_level = indicator_in;
	end

	// capture on the first edge after reset release, then freeze
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg <= ST_SAMPLE;
		end else begin
			case (state_reg)
				ST_SAMPLE: state_reg <= ST_HOLD;
				ST_HOLD: state_reg <= ST_HOLD;
				default: state_reg <= ST_SAMPLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cfg_reg <= '0;
		end else if (state_reg == ST_SAMPLE) begin
			cfg_reg <= cfg_next;
		end
	end

	assign cfg = cfg_reg;
	assign strap_valid = (state_reg == ST_HOLD);
endmodule
`default_nettype wire

// >>> logic/scfg_ext_window.sv
`timescale 1ns/1ps
`default_nettype none
module scfg_ext_window (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// strobes from the register port
	input wire logic ctrl_write,
	input wire logic data_write,
	input wire logic data_read,
	input wire logic [15:0] wdata,
	// window state
	output logic [15:0] ctrl_value,
	output logic [11:0] ext_address,
	output logic [4:0] field,
	output logic data_mode
);
	import scfg_pkg::*;

	logic [15:0] ctrl_reg;
	logic [11:0] addr_reg;
	scfg_ind_fn_t fn;

	assign fn = scfg_ind_fn_t'(ctrl_reg[IND_FN_LSB +: 2]);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl_reg <= 16'h0000;
		end else if (ctrl_write) begin
			ctrl_reg <= wdata;
		end
	end

	// post increment keeps bursts cheap for the manager
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			addr_reg <= 12'h000;
		end else if (data_write && fn == IND_FN_ADDR) begin
			addr_reg <= wdata[EXT_ADDR_W-1:0];
		end else if ((data_write || data_read) && fn == IND_FN_DATA_INC_RW) begin
			addr_reg <= addr_reg + 12'h001;
		end else if (data_write && fn == IND_FN_DATA_INC_WR) begin
			addr_reg <= addr_reg + 12'h001;
		end
	end

	assign ctrl_value = ctrl_reg;
	assign ext_address = addr_reg;
	assign field = ctrl_reg[IND_FIELD_W-1:0];
	assign data_mode = (fn != IND_FN_ADDR);
endmodule
`default_nettype wire

// >>> logic/scfg_top.sv
`timescale 1ns/1ps
`default_nettype none
module scfg_top #(
	parameter int LED_SRC_W = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// strap levels of the shared receive pins
	input wire scfg_pkg::scfg_strap_pins_t strap_pins,
	// management register port
	input wire scfg_pkg::scfg_mgmt_req_t mgmt_req,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_ack,
	// phy status sources
	input wire logic link_fault,
	input wire logic link_ok,
	input wire logic rx_error_event,
	input wire logic restart_done,
	input wire logic [LED_SRC_W-1:0] led_source,
	input wire logic clock_out_source,
	// indicator pins
	input wire logic indicator_out_zero_in,
	output logic indicator_out_zero,
	output logic indicator_out_zero_oe,
	input wire logic indicator_out_one_in,
	output logic indicator_out_one,
	output logic indicator_out_one_oe,
	input wire logic indicator_out_two_in,
	output logic indicator_out_two,
	output logic indicator_out_two_oe,
	// decoded configuration
	output scfg_pkg::scfg_strap_cfg_t strap_cfg,
	output logic strap_valid,
	output logic link_enable,
	output logic link_restart
);
	import scfg_pkg::*;

	logic [15:0] led_cfg_reg;
	logic link_permit_reg;
	logic restart_reg;
	logic fault_lh_reg;
	logic link_ll_reg;
	logic [ERRCNT_W-1:0] err_cnt_reg;
	logic [15:0] rdata_reg;
	logic ack_reg;
	logic [2:0] led_q_reg;

	logic hit;
	logic ctrl_write, data_write, data_read;
	logic [15:0] ind_ctrl;
	logic [11:0] ind_addr;
	logic [4:0] ind_field;
	logic ind_data_mode;
	logic acc_vendor;
	logic acc_read, acc_write;
	logic [11:0] acc_addr;
	logic [15:0] rd_value;
	logic stat_read;
	logic [2:0] led_on;

	scfg_strap_latch u_strap (
		.clock(clock),
		.reset(reset),
		.pins(strap_pins),
		.indicator_in({indicator_out_two_in, indicator_out_one_in, indicator_out_zero_in}),
		.cfg(strap_cfg),
		.strap_valid(strap_valid)
	);

	scfg_ext_window u_window (
		.clock(clock),
		.reset(reset),
		.ctrl_write(ctrl_write),
		.data_write(data_write),
		.data_read(data_read),
		.wdata(mgmt_req.wdata),
		.ctrl_value(ind_ctrl),
		.ext_address(ind_addr),
		.field(ind_field),
		.data_mode(ind_data_mode)
	);

	// only frames for our own strapped address are answered
	assign hit = mgmt_req.valid && strap_valid && (mgmt_req.port == strap_cfg.port_address_strap);
	assign ctrl_write = hit && mgmt_req.write && (mgmt_req.regnum == REG_IND_CTRL);
	assign data_write = hit && mgmt_req.write && (mgmt_req.regnum == REG_IND_DATA);
	assign data_read = hit && !mgmt_req.write && (mgmt_req.regnum == REG_IND_DATA);

	function automatic logic [15:0] vendor_read(input logic [11:0] a);
		logic [15:0] v;
		v = 16'h0000;
		if (a == {7'h00, REG_IND_CTRL}) begin
			v = ind_ctrl;
		end else if (a == {7'h00, REG_IND_DATA}) begin
			v = {4'h0, ind_addr};
		end else if (a == {7'h00, REG_LINK_CTRL}) begin
			v[LINK_PERMIT_BIT] = link_permit_reg;
			v[LINK_RESTART_BIT] = restart_reg;
		end else if (a == {7'h00, REG_LINK_STAT}) begin
			v[STAT_FAULT_BIT] = fault_lh_reg;
			v[STAT_LINK_BIT] = link_ll_reg;
			v[STAT_ERRCNT_LSB +: ERRCNT_W] = err_cnt_reg;
		end else if (a == {7'h00, REG_STRAP_STAT}) begin
			v = {1'b0, strap_cfg.host_interface_select, strap_cfg.test_mode,
				strap_cfg.port_address_strap[3:0], strap_cfg.master_slave_strap,
				strap_cfg.managed_start, strap_cfg.indicator_level};
		end else if (a == EXT_LED_CFG) begin
			v = led_cfg_reg;
		end
		vendor_read = v;
	endfunction

	// one access path serves direct registers and the indirect window
	always_comb begin
		acc_vendor = 1'b1;
		acc_addr = {7'h00, mgmt_req.regnum};
		acc_read = hit && !mgmt_req.write;
		acc_write = hit && mgmt_req.write;
		if (mgmt_req.regnum == REG_IND_CTRL) begin
			acc_write = 1'b0;
		end else if (mgmt_req.regnum == REG_IND_DATA) begin
			if (ind_data_mode) begin
				acc_addr = ind_addr;
				acc_vendor = (ind_field == FIELD_VENDOR);
				// the window never rewrites its own pointer registers
				if (ind_addr == {7'h00, REG_IND_CTRL} || ind_addr == {7'h00, REG_IND_DATA}) begin
					acc_write = 1'b0;
				end
			end else begin
				acc_write = 1'b0;
			end
		end
	end

	// pma field is addressable over 0x0..0xfff but holds no local registers
	assign rd_value = acc_vendor ? vendor_read(acc_addr) : 16'h0000;
	assign stat_read = acc_read && acc_vendor && (acc_addr == {7'h00, REG_LINK_STAT});

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_reg <= 16'h0000;
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= hit;
			if (acc_read) begin
				rdata_reg <= rd_value;
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			led_cfg_reg <= LED_CFG_RESET;
		end else if (acc_write && acc_vendor && acc_addr == EXT_LED_CFG) begin
			led_cfg_reg <= mgmt_req.wdata;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			link_permit_reg <= LINK_PERMIT_RESET;
		end else if (acc_write && acc_vendor && acc_addr == {7'h00, REG_LINK_CTRL}) begin
			link_permit_reg <= mgmt_req.wdata[LINK_PERMIT_BIT];
		end
	end

	// self-clearing restart: a new request in the done cycle wins
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			restart_reg <= 1'b0;
		end else if (acc_write && acc_vendor && acc_addr == {7'h00, REG_LINK_CTRL}
			&& mgmt_req.wdata[LINK_RESTART_BIT]) begin
			restart_reg <= 1'b1;
		end else if (restart_done) begin
			restart_reg <= 1'b0;
		end
	end

	// latched bits: an event in the read cycle is kept, not lost
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fault_lh_reg <= 1'b0;
			link_ll_reg <= 1'b0;
		end else begin
			fault_lh_reg <= link_fault || (fault_lh_reg && !stat_read);
			link_ll_reg <= link_ok && (link_ll_reg || stat_read);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			err_cnt_reg <= '0;
		end else if (stat_read) begin
			err_cnt_reg <= {{(ERRCNT_W-1){1'b0}}, rx_error_event};
		end else if (rx_error_event && err_cnt_reg != ERRCNT_MAX) begin
			err_cnt_reg <= err_cnt_reg + 1'b1;
		end
	end

	// slave ignores the autonomous strap; managed master waits for permit
	always_comb begin
		link_enable = strap_valid && (!strap_cfg.master_slave_strap
			|| !strap_cfg.managed_start || link_permit_reg);
	end

	// indicators
	assign led_on[0] = led_source[led_cfg_reg[LED0_SEL_LSB +: LED_SEL_W]];
	assign led_on[1] = led_source[led_cfg_reg[LED1_SEL_LSB +: LED_SEL_W]];
	assign led_on[2] = led_source[led_cfg_reg[LED2_SEL_LSB +: LED_SEL_W]];

	// a pulled-up strap means the led hangs from the supply, so drive low to light
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			led_q_reg <= 3'h0;
		end else begin
			led_q_reg <= led_on ^ strap_cfg.indicator_level;
		end
	end

	// pins stay released until the straps are taken, to avoid contention
	assign indicator_out_zero_oe = strap_valid;
	assign indicator_out_one_oe = strap_valid;
	assign indicator_out_two_oe = strap_valid;
	assign indicator_out_zero = led_q_reg[0];
	assign indicator_out_one = led_q_reg[1];
	assign indicator_out_two = led_cfg_reg[REFERENCE_CLOCK_OUTPUT_SEL_BIT] ? clock_out_source : led_q_reg[2];

	assign mgmt_rdata = rdata_reg;
	assign mgmt_ack = ack_reg;
	assign link_restart = restart_reg;
endmodule
`default_nettype wire

// >>> test/scfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module scfg_checker (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// register port
	input wire scfg_pkg::scfg_mgmt_req_t mgmt_req,
	input wire logic mgmt_ack,
	// decoded straps and pins
	input wire scfg_pkg::scfg_strap_cfg_t strap_cfg,
	input wire logic strap_valid,
	input wire logic indicator_out_zero_oe,
	input wire logic indicator_out_one_oe,
	input wire logic indicator_out_two_oe,
	input wire logic link_enable
);
	import scfg_pkg::*;
	logic take;
	assign take = mgmt_req.valid && strap_valid && mgmt_req.port == strap_cfg.port_address_strap;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_take;
		take;
	endsequence
	sequence s_ack;
		##1 mgmt_ack;
	endsequence
	property p_ack;
		s_take |-> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("matched request not acked");
	property p_no_ack;
		!take |=> !mgmt_ack;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack without a matched request");
	property p_addr_top;
		strap_valid |-> strap_cfg.port_address_strap[4] == 1'b0;
	endproperty
	a_addr_top: assert property (p_addr_top) else $error("port address above 15");
	property p_hold;
		strap_valid && $past(strap_valid) |-> $stable(strap_cfg);
	endproperty
	a_hold: assert property (p_hold) else $error("decoded straps moved");
	property p_test_code;
		strap_valid |-> strap_cfg.test_mode inside {TEST_NORMAL, TEST_MODE_1, TEST_MODE_2,
			TEST_MODE_4, TEST_MODE_5, TEST_RESERVED};
	endproperty
	a_test_code: assert property (p_test_code) else $error("bad test decode");
	property p_oe;
		{indicator_out_two_oe, indicator_out_one_oe, indicator_out_zero_oe} == {3{strap_valid}};
	endproperty
	a_oe: assert property (p_oe) else $error("indicator enable wrong");
	property p_auto;
		strap_valid && !(strap_cfg.master_slave_strap && strap_cfg.managed_start) |-> link_enable;
	endproperty
	a_auto: assert property (p_auto) else $error("link not started alone");
	property p_link_off;
		!strap_valid |-> !link_enable;
	endproperty
	a_link_off: assert property (p_link_off) else $error("link before straps");
	// first edge after release samples the straps, valid follows one edge later
	sequence s_latch;
		!strap_valid ##1 strap_valid;
	endsequence
	property p_valid;
		$fell(reset) |-> s_latch;
	endproperty
	a_valid: assert property (p_valid) else $error("straps not latched");
endmodule
bind scfg_top scfg_checker i_chk (.clock(clock), .reset(reset), .mgmt_req(mgmt_req),
	.mgmt_ack(mgmt_ack), .strap_cfg(strap_cfg), .strap_valid(strap_valid),
	.indicator_out_zero_oe(indicator_out_zero_oe), .indicator_out_one_oe(indicator_out_one_oe),
	.indicator_out_two_oe(indicator_out_two_oe), .link_enable(link_enable));
`default_nettype wire

// >>> test/scfg_straps.sv
`timescale 1ns/1ps
`default_nettype none
module scfg_straps (
	// clock and latch state
	input wire logic clock,
	input wire logic strap_valid,
	// board strap choice
	input wire logic [3:0] addr,
	input wire logic [2:0] mac,
	input wire logic [2:0] test,
	input wire logic [2:0] ind,
	// indicator pins
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	output logic [2:0] pin_level,
	output scfg_pkg::scfg_strap_pins_t pins
);
	import scfg_pkg::*;
	logic [1:0] churn = 2'h0;
	scfg_strap_pins_t strap;
	function automatic logic [1:0] code(input logic f, input logic s);
		code = {f, f ^ s};
	endfunction
	always @(posedge clock) churn <= churn + 2'h1;
	always_comb begin
		strap.rx_valid = code(addr[0], addr[2]);
		strap.rx_error = code(addr[1], addr[3]);
		for (int i = 0; i < 3; i++) strap.rx_data[i] = code(mac[i], test[i]);
	end
	// after latching the shared pins carry traffic, never the strap levels
	assign pins = strap_valid ? scfg_strap_pins_t'(strap ^ {5{churn | 2'h1}}) : strap;
	// resistor level wins only while the pin is not driven
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ind);
endmodule
`default_nettype wire

// >>> test/scfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scfg_top_tb;
	import scfg_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	scfg_strap_pins_t strap_pins;
	scfg_mgmt_req_t mgmt_req = '0;
	scfg_strap_cfg_t strap_cfg;
	logic [15:0] mgmt_rdata, got;
	logic [15:0] led_source = 16'h0000;
	logic mgmt_ack, strap_valid, link_enable, seen_ack, link_restart;
	logic link_fault = 1'b0, link_ok = 1'b0, err_event = 1'b0, restart_done = 1'b0;
	logic clk_src = 1'b0;
	wire [2:0] ind_out, ind_oe, ind_in;
	logic [3:0] addr = 4'h0;
	logic [2:0] k3 = 3'h0;
	logic [2:0] ind = 3'h0;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	scfg_top i_dut (.clock(clock), .reset(reset), .strap_pins(strap_pins), .mgmt_req(mgmt_req),
		.mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack), .link_fault(link_fault),
		.link_ok(link_ok), .rx_error_event(err_event), .restart_done(restart_done),
		.led_source(led_source), .clock_out_source(clk_src), .indicator_out_zero_in(ind_in[0]),
		.indicator_out_zero(ind_out[0]), .indicator_out_zero_oe(ind_oe[0]),
		.indicator_out_one_in(ind_in[1]), .indicator_out_one(ind_out[1]),
		.indicator_out_one_oe(ind_oe[1]), .indicator_out_two_in(ind_in[2]),
		.indicator_out_two(ind_out[2]), .indicator_out_two_oe(ind_oe[2]),
		.strap_cfg(strap_cfg), .strap_valid(strap_valid), .link_enable(link_enable),
		.link_restart(link_restart));
	scfg_straps i_straps (.clock(clock), .strap_valid(strap_valid), .addr(addr), .mac(k3),
		.test(k3), .ind(ind), .pin_out(ind_out), .pin_oe(ind_oe), .pin_level(ind_in),
		.pins(strap_pins));
	initial forever #25 clock = ~clock;
	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic xfer(input logic w, input logic [4:0] r, input logic [15:0] d,
		input logic [4:0] p);
		@(posedge clock);
		mgmt_req <= '{1'b1, w, p, r, d};
		@(posedge clock);
		mgmt_req.valid <= 1'b0;
		#1 got = mgmt_rdata;
		seen_ack = mgmt_ack;
	endtask
	task automatic wr(input logic [4:0] r, input logic [15:0] d);
		xfer(1'b1, r, d, {1'b0, addr});
		chk(seen_ack, 1'b1);
	endtask
	task automatic rd(input logic [4:0] r, input logic [15:0] want);
		xfer(1'b0, r, 16'h0000, {1'b0, addr});
		chk(seen_ack, 1'b1);
		chk(got, want);
	endtask
	// manager side of the window: field, address, then data mode
	task automatic ext(input logic [4:0] f, input logic [11:0] a);
		wr(REG_IND_CTRL, {11'h000, f});
		wr(REG_IND_DATA, {4'h0, a});
		wr(REG_IND_CTRL, {2'h1, 9'h000, f});
	endtask
	function automatic logic [2:0] tdec(input logic [2:0] c);
		tdec = (c == 3'h3 || c >= 3'h6) ? 3'h7 : c;
	endfunction
	initial begin
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			reset <= 1'b1;
			k3 <= k[2:0];
			addr <= {k[2:0], k[0]};
			ind <= k[2:0];
			repeat (8) @(posedge clock);
			reset <= 1'b0;
			repeat (2) @(posedge clock);
			#1 chk(strap_cfg.host_interface_select, k3);
			chk(strap_cfg.test_mode, tdec(k3));
			chk(strap_cfg.port_address_strap, {1'b0, addr});
			chk(strap_cfg.master_slave_strap, ind[0]);
			chk(strap_cfg.managed_start, ind[1]);
			chk(strap_cfg.indicator_level, ind);
			chk(link_enable, !(ind[0] && ind[1]));
			chk(ind_out, ind);
			chk(ind_oe, 3'h7);
			rd(REG_STRAP_STAT, {1'b0, k3, tdec(k3), addr, ind[0], ind[1], ind});
			xfer(1'b0, REG_STRAP_STAT, 16'h0000, {1'b1, addr});
			chk(seen_ack, 1'b0);
			wr(REG_LINK_CTRL, 16'h0001);
			@(posedge clock);
			#1 chk(link_enable, 1'b1);
			chk(strap_cfg.port_address_strap, {1'b0, addr});
		end
		rd(5'h1b, 16'h0000);
		ext(FIELD_VENDOR, EXT_LED_CFG);
		wr(REG_IND_DATA, 16'h0005);
		ext(FIELD_VENDOR, EXT_LED_CFG);
		rd(REG_IND_DATA, 16'h0005);
		@(posedge clock);
		led_source <= 16'h0020;
		repeat (2) @(posedge clock);
		#1 chk(ind_out, ind ^ 3'h1);
		ext(FIELD_VENDOR, {7'h00, REG_LINK_CTRL});
		rd(REG_IND_DATA, 16'h0001);
		ext(FIELD_PMA, 12'h007);
		rd(REG_IND_DATA, 16'h0000);
		// latched status bits and the error count across reads
		@(posedge clock);
		link_ok <= 1'b1;
		link_fault <= 1'b1;
		err_event <= 1'b1;
		@(posedge clock);
		link_fault <= 1'b0;
		err_event <= 1'b0;
		rd(REG_LINK_STAT, 16'h0101);
		@(posedge clock);
		link_ok <= 1'b0;
		@(posedge clock);
		link_ok <= 1'b1;
		rd(REG_LINK_STAT, 16'h0000);
		rd(REG_LINK_STAT, 16'h0002);
		// restart request stands until the done pulse
		wr(REG_LINK_CTRL, 16'h8001);
		chk(link_restart, 1'b1);
		rd(REG_LINK_CTRL, 16'h8001);
		@(posedge clock);
		restart_done <= 1'b1;
		@(posedge clock);
		restart_done <= 1'b0;
		#1 chk(link_restart, 1'b0);
		rd(REG_LINK_CTRL, 16'h0001);
		// indicator two carries the clock once selected
		ext(FIELD_VENDOR, EXT_LED_CFG);
		wr(REG_IND_DATA, 16'h1005);
		chk(ind_out, 3'h2);
		@(posedge clock);
		clk_src <= 1'b1;
		#1 chk(ind_out, 3'h6);
		finish_test();
	end
endmodule
`default_nettype wire
